// ### src/modem_power_fsm.sv
/*
 * Module-side power state machine: boot on a power key press, USB enumeration,
 * shutdown command, power key turn-off, reset and emergency off.
 * Assumes the host end of power_link and a 100 MHz ref_clk standing in for module time.
 */
`timescale 1ns/100ps
module modem_power_fsm #(
	parameter int unsigned MS_CYCLES = power_seq_pkg::MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	power_link.modem link,
	input wire logic quiet_boot_option,
	output logic module_active,
	output logic rx_bit
);
	import power_seq_pkg::*;

	typedef struct packed {
		dev_state_e state;
		logic [15:0] cnt;
		logic [15:0] key_ms;
		logic [15:0] rst_ms;
		logic armed;
		logic key_seen_high;
		logic long_hold;
		logic restart;
		logic enumerated;
		logic rail;
		logic safe_n;
		logic usb_enum;
		logic active;
		logic rx;
	} dev_s;

	dev_s s;
	dev_s next_s;
	logic tick;
	logic key_low;
	logic rst_low;
	logic [15:0] boot_ms;

	ms_tick #(
		.CYCLES(MS_CYCLES)
	) u_tick (
		.ref_clk(ref_clk),
		.rst(rst),
		.tick(tick)
	);

	assign key_low = ~link.power_key_n;
	assign rst_low = ~link.emerg_reset_n;
	assign boot_ms = quiet_boot_option ? T_BOOT_QUIET_MS : T_BOOT_MS; // RQ5

	// Fresh boot: a new power-on, so a new single enumeration is due.
	function automatic dev_s go_boot(input dev_s x);
		dev_s y;
		y = x;
		y.state = D_BOOT;
		y.cnt = 16'h0000;
		y.enumerated = 1'b0;
		y.long_hold = 1'b0;
		y.rail = 1'b0;
		y.safe_n = 1'b1;
		y.active = 1'b0;
		return y;
	endfunction

	// Power state machine. Losing supply wins over everything.
	always_comb begin
		next_s = s;
		next_s.usb_enum = 1'b0;
		next_s.rx = link.host_io & s.active;
		next_s.cnt = ms_step(s.cnt, tick);
		next_s.key_ms = key_low ? ms_step(s.key_ms, tick) : 16'h0000;
		next_s.rst_ms = rst_low ? ms_step(s.rst_ms, tick) : 16'h0000;
		if (!key_low) begin
			next_s.armed = 1'b1;
			next_s.key_seen_high = 1'b1;
		end
		if (!link.main_supply) begin
			next_s = '0;
			next_s.state = D_NOPWR;
		end else if (rst_low && (s.state == D_BOOT || s.state == D_ACTIVE ||
				s.state == D_OFFSEQ)) begin
			// Any reset pulse stops the module, whatever the key does.
			next_s.state = D_RESET; // RQ11
			next_s.rail = 1'b0; // RQ3
			next_s.active = 1'b0;
		end else begin
			case (s.state)
				D_NOPWR: begin
					// A key held while supply arrives counts from this point.
					next_s.state = D_OFF; // RQ10
					next_s.armed = 1'b1;
				end
				D_OFF: begin
					next_s.rail = 1'b0;
					next_s.safe_n = 1'b0;
					if (s.armed && s.key_ms >= T_KEY_ON_MIN_MS) begin // RQ6 RQ10
						next_s = go_boot(next_s);
					end
				end
				D_BOOT: begin
					if (s.key_ms > T_KEY_ON_MAX_MS) begin
						next_s.long_hold = 1'b1; // RQ16
					end
					if (s.cnt >= T_RAIL_UP_MS) begin
						next_s.rail = 1'b1; // RQ1
					end
					if (s.cnt >= boot_ms) begin
						next_s.state = D_ACTIVE;
						next_s.active = 1'b1;
						next_s.key_seen_high = ~key_low;
						next_s.enumerated = 1'b1;
						next_s.usb_enum = ~s.enumerated; // RQ7
					end
				end
				D_ACTIVE: begin
					if (link.shutdown_command) begin
						next_s.state = D_OFFSEQ;
						next_s.restart = key_low; // RQ12 RQ13
						next_s.active = 1'b0;
						next_s.cnt = 16'h0000;
					end else if (s.long_hold && !key_low) begin
						next_s.state = D_OFFSEQ; // RQ16
						next_s.restart = 1'b0;
						next_s.active = 1'b0;
						next_s.cnt = 16'h0000;
					end else if (s.key_seen_high && s.key_ms > T_KEY_OFF_MS) begin
						// Only a press begun while active counts, not the boot press.
						next_s.state = D_OFFSEQ; // RQ15
						next_s.restart = 1'b0;
						next_s.active = 1'b0;
						next_s.cnt = 16'h0000;
					end
				end
				D_OFFSEQ: begin
					// Safe flag falls first, then the rail, well inside 6 s.
					if (s.cnt >= T_OFF_DEV_MS) begin
						next_s.safe_n = 1'b0; // RQ8
					end
					if (s.cnt >= T_OFF_DEV_MS + T_PWR_REMOVE_MS) begin
						next_s.rail = 1'b0;
						next_s.armed = 1'b0;
						next_s.state = D_OFF;
						if (s.restart) begin
							next_s = go_boot(next_s); // RQ12
						end
					end
				end
				D_RESET: begin
					if (!rst_low) begin
						next_s = go_boot(next_s); // RQ11
					end else if (s.rst_ms >= T_EMERG_MS && !key_low) begin
						// Emergency off drops everything at once.
						next_s.state = D_OFF; // RQ9
						next_s.safe_n = 1'b0;
						next_s.armed = 1'b0;
					end
				end
				default: begin
					next_s.state = D_NOPWR;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.state <= D_NOPWR;
		end else begin
			s <= next_s;
		end
	end

	assign link.io_rail_good = s.rail;
	assign link.safe_to_unpower_n = s.safe_n;
	assign link.usb_enum = s.usb_enum;
	assign module_active = s.active;
	assign rx_bit = s.rx;
endmodule

// ### src/power_seq_pkg.sv
/*
 * Shared constants, state encodings and helpers for the module power sequencer pair.
 * Assumes a single 100 MHz clock in both ends and a one millisecond tick derived from it.
 */
package power_seq_pkg;

	// Clock period and the millisecond tick derived from it.
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned T_MS_NS = 1000000;
	localparam int unsigned MS_CYCLES = (T_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Interval lengths, all in milliseconds.
	localparam logic [15:0] T_RAIL_UP_MS = 16'h0064;      // 100 ms rail rise after boot.
	localparam logic [15:0] T_KEY_ON_MIN_MS = 16'h00C8;   // 200 ms least press.
	localparam logic [15:0] T_KEY_ON_MAX_MS = 16'h1B58;   // 7000 ms longest press.
	localparam logic [15:0] T_KEY_OFF_MS = 16'h03E8;      // 1000 ms hold to turn off.
	localparam logic [15:0] T_BOOT_MS = 16'h1B58;         // 7000 ms typical boot.
	localparam logic [15:0] T_BOOT_QUIET_MS = 16'h7530;   // 30000 ms boot, quiet option.
	localparam logic [15:0] T_ON_SEQ_MAX_MS = 16'h5DC0;   // 24000 ms longest boot.
	localparam logic [15:0] T_OFF_SEQ_MAX_MS = 16'h1770;  // 6000 ms longest power-off.
	localparam logic [15:0] T_OFF_DEV_MS = 16'h01F4;      // 500 ms device power-off work.
	localparam logic [15:0] T_PWR_REMOVE_MS = 16'h000D;   // 13 ms safe flag to rail fall.
	localparam logic [15:0] T_EMERG_MS = 16'h1F40;        // 8000 ms emergency hold.
	localparam logic [15:0] T_EMERG_HOLD_MS = 16'h1FA4;   // 8100 ms host hold, with margin.
	localparam logic [15:0] T_PRESS_MS = 16'h012C;        // 300 ms host press.

	// Device power states.
	typedef enum logic [5:0] {
		D_NOPWR = 6'h01,
		D_OFF = 6'h02,
		D_BOOT = 6'h04,
		D_ACTIVE = 6'h08,
		D_OFFSEQ = 6'h10,
		D_RESET = 6'h20
	} dev_state_e;

	// Host sequencer states.
	typedef enum logic [7:0] {
		H_OFF = 8'h01,
		H_PRESS = 8'h02,
		H_BOOT = 8'h04,
		H_ACTIVE = 8'h08,
		H_CMD = 8'h10,
		H_DOWN = 8'h20,
		H_KILL = 8'h40,
		H_UNPWR = 8'h80
	} host_state_e;

	// Saturating millisecond count; saturation keeps long holds from wrapping to short.
	function automatic logic [15:0] ms_step(input logic [15:0] c, input logic t);
		return (t && c != 16'hFFFF) ? c + 16'h0001 : c;
	endfunction

endpackage

// ### src/power_link.sv
/*
 * Wires between the host sequencer and the module power logic.
 * Assumes the module pulls the power key and emergency reset up, and pulls host data down.
 */
`timescale 1ns/100ps
interface power_link;
	logic main_supply;
	logic power_key_n_o;
	logic power_key_oe;
	logic power_key_n;
	logic emerg_reset_n_o;
	logic emerg_reset_oe;
	logic emerg_reset_n;
	logic shutdown_command;
	logic io_rail_good;
	logic safe_to_unpower_n;
	logic usb_enum;
	logic host_io_o;
	logic host_io_oe;
	logic host_io;

	// Open-drain levels with the module's pull-ups, and the data pin with a pull-down.
	assign power_key_n = power_key_oe ? power_key_n_o : 1'b1;
	assign emerg_reset_n = emerg_reset_oe ? emerg_reset_n_o : 1'b1;
	assign host_io = host_io_oe & host_io_o;

	modport host (
		output main_supply, power_key_n_o, power_key_oe, emerg_reset_n_o, emerg_reset_oe,
		output shutdown_command, host_io_o, host_io_oe,
		input power_key_n, emerg_reset_n, io_rail_good, safe_to_unpower_n, usb_enum
	);
	modport modem (
		input main_supply, power_key_n, emerg_reset_n, shutdown_command, host_io,
		output io_rail_good, safe_to_unpower_n, usb_enum
	);
endinterface

// ### src/ms_tick.sv
/*
 * Free-running divider giving a one-cycle pulse every millisecond.
 * Assumes CYCLES is at least two.
 */
`timescale 1ns/100ps
module ms_tick #(
	parameter int unsigned CYCLES = power_seq_pkg::MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} tick_s;

	tick_s s;
	tick_s next_s;

	// Wrap at CYCLES-1 and pulse on the wrap.
	always_comb begin
		next_s = s;
		next_s.tick = (s.cnt == 32'(CYCLES - 1));
		next_s.cnt = next_s.tick ? 32'h0000_0000 : s.cnt + 32'h0000_0001;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;
endmodule

// ### src/host_power_seq.sv
/*
 * Host-side power sequencer: supplies the module, presses its power key, sends the
 * shutdown command, applies the emergency reset and gates its own data pin.
 * Assumes the module end on the other side of power_link and a 100 MHz ref_clk.
 * Requests are levels sampled each edge; one the current state cannot take is dropped.
 */
// Notes on behaviour
// (RQ1) No host drive before rail good rises.
// (RQ2) Host pins released until module is active.
// (RQ3) Host pins released during reset or power-off.
// (RQ4) Release pins before rail falls after shutdown.
// (RQ5) Module boots within 24 s, quiet off.
// (RQ6) Power key press between 200 ms and 7 s.
// (RQ7) One USB enumeration, within boot maximum.
// (RQ8) Unpower only when rail and safe low.
// (RQ9) Emergency off: key released, reset 8 s.
// (RQ10) Key-before-supply and supply-before-key both start.
// (RQ11) Short reset resets, key held or not.
// (RQ12) Shutdown with key held restarts module.
// (RQ13) Shutdown with key released turns off.
// (RQ14) Emergency reset only for a frozen module.
// (RQ15) Active module: key over 1 s turns off.
// (RQ16) Key over 7 s at boot: off on release.
// (RQ17) Free-running timing, timeouts flag missing edges.
`timescale 1ns/100ps
module host_power_seq #(
	parameter int unsigned MS_CYCLES = power_seq_pkg::MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	power_link.host link,
	input wire logic start_req,
	input wire logic stop_req,
	input wire logic kill_req,
	input wire logic tx_bit,
	output logic module_up,
	output logic busy,
	output logic timeout_fault
);
	import power_seq_pkg::*;

	// Pin drives and user outputs live here, so that each comes from a flop.
	typedef struct packed {
		host_state_e state;
		logic [15:0] cnt;
		logic supply;
		logic key_oe;
		logic key_n_o;
		logic rst_oe;
		logic rst_n_o;
		logic cmd;
		logic io_oe;
		logic io_o;
		logic up;
		logic busy;
		logic fault;
	} host_s;

	// The whole sequencer state is one register; next_s is its next value.
	host_s s;
	host_s next_s;
	logic tick;

	// One millisecond time base, free running from reset.
	ms_tick #(
		.CYCLES(MS_CYCLES)
	) u_tick (
		.ref_clk(ref_clk),
		.rst(rst),
		.tick(tick)
	);

	// Sequencer. The boot and power-off waits are timed on the free-running tick so that a
	// missing indication edge is flagged; the key-low and reset-low waits have no timeout.
	always_comb begin
		next_s = s;
		next_s.cmd = 1'b0;
		next_s.cnt = ms_step(s.cnt, tick); // RQ17
		case (s.state)
			H_OFF: begin
				// Supply stays off and nothing is driven toward the module here.
				next_s.supply = 1'b0;
				next_s.up = 1'b0;
				if (start_req) begin
					// Supply and key go together; the module accepts either order.
					next_s.state = H_PRESS;
					next_s.supply = 1'b1;
					next_s.key_oe = 1'b1;
					next_s.cnt = 16'h0000;
					next_s.fault = 1'b0;
				end
			end
			H_PRESS: begin
				// The hold is timed from the key being seen low, well below the ceiling.
				if (link.power_key_n) begin
					// The count restarts until the key has been seen low.
					next_s.cnt = 16'h0000;
				end else if (s.cnt >= T_PRESS_MS) begin // RQ6
					next_s.state = H_BOOT;
					next_s.key_oe = 1'b0;
					next_s.cnt = 16'h0000;
				end
			end
			H_BOOT: begin
				// Key is released; wait for the one enumeration, and flag a fault at 24 s but keep waiting.
				if (kill_req) begin
					// A module that hangs in boot can still be forced off.
					next_s.state = H_KILL;
					next_s.key_oe = 1'b0;
					next_s.rst_oe = 1'b1;
					next_s.cnt = 16'h0000;
				end else if (link.usb_enum) begin // RQ7
					next_s.state = H_ACTIVE;
					next_s.up = 1'b1;
				end else if (s.cnt >= T_ON_SEQ_MAX_MS) begin // RQ5
					next_s.fault = 1'b1; // RQ17
				end
			end
			H_ACTIVE: begin
				if (kill_req) begin
					// Software asks for this only when the module no longer answers.
					next_s.state = H_KILL; // RQ14
					next_s.key_oe = 1'b0; // RQ9
					next_s.rst_oe = 1'b1;
					next_s.up = 1'b0;
					next_s.cnt = 16'h0000;
				end else if (!link.io_rail_good) begin
					// Module went into reset or off on its own; wait for it again.
					next_s.state = H_BOOT; // RQ3
					next_s.up = 1'b0;
					next_s.cnt = 16'h0000;
				end else if (stop_req) begin
					// Leaving ACTIVE drops the data pin on this edge, before the command.
					next_s.state = H_CMD;
					next_s.up = 1'b0;
				end
			end
			H_CMD: begin
				// Data pin is already released here, one cycle before the command.
				next_s.cmd = 1'b1; // RQ4
				next_s.state = H_DOWN;
				next_s.cnt = 16'h0000;
			end
			H_DOWN: begin
				// Wait for both indications low; only then may supply be dropped.
				if (kill_req) begin
					next_s.state = H_KILL;
					next_s.rst_oe = 1'b1;
					next_s.cnt = 16'h0000;
				end else if (!link.io_rail_good && !link.safe_to_unpower_n) begin // RQ8
					next_s.state = H_UNPWR;
				end else if (s.cnt >= T_OFF_SEQ_MAX_MS) begin
					next_s.fault = 1'b1; // RQ17
				end
			end
			H_KILL: begin
				// The hold carries margin so the module's own count surely reaches 8 s.
				if (link.emerg_reset_n) begin
					next_s.cnt = 16'h0000;
				end else if (s.cnt >= T_EMERG_HOLD_MS) begin // RQ9
					// Release the reset and take the normal wait for rail and safe flag.
					next_s.state = H_DOWN;
					next_s.rst_oe = 1'b0;
					next_s.cnt = 16'h0000;
				end
			end
			H_UNPWR: begin
				// Supply goes one cycle after both indications were seen low.
				next_s.state = H_OFF;
				next_s.supply = 1'b0;
			end
			default: begin
				// Any stray code returns to the safe, unpowered state.
				next_s.state = H_OFF;
			end
		endcase

		// Data pin drives only while active and with the rail up; otherwise it floats.
		// Limitation: the rail is seen through a register, so if the module drops it
		// on its own the pin is released one cycle late. Host-led shutdown and kill
		// release the pin before the module can react, so they never meet this lag.
		next_s.io_oe = (next_s.state == H_ACTIVE) && link.io_rail_good; // RQ1 RQ2 RQ3
		next_s.io_o = next_s.io_oe & tx_bit;
		next_s.busy = (next_s.state != H_OFF) && (next_s.state != H_ACTIVE);
	end

	// State register; the asynchronous reset leaves every pin released.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.state <= H_OFF;
		end else begin
			s <= next_s;
		end
	end

	// Pins and user outputs come straight from the state register.
	assign link.main_supply = s.supply;
	assign link.power_key_oe = s.key_oe;
	assign link.power_key_n_o = s.key_n_o;
	assign link.emerg_reset_oe = s.rst_oe;
	assign link.emerg_reset_n_o = s.rst_n_o;
	assign link.shutdown_command = s.cmd;
	assign link.host_io_oe = s.io_oe;
	assign link.host_io_o = s.io_o;
	assign module_up = s.up;
	assign busy = s.busy;
	assign timeout_fault = s.fault;
endmodule

// ### bench/power_link_sva.sv
/* Assertions on the power link between the host sequencer and the module state machine.
   Assumes it sits beside the link, fed with its wires and the shared clock and reset. */
`timescale 1ns/100ps
module power_link_sva
	import power_seq_pkg::*;
#(
	parameter int unsigned MS_CYCLES = power_seq_pkg::MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic main_supply,
	input wire logic power_key_oe,
	input wire logic power_key_n,
	input wire logic emerg_reset_n,
	input wire logic shutdown_command,
	input wire logic io_rail_good,
	input wire logic safe_to_unpower_n,
	input wire logic usb_enum,
	input wire logic host_io_oe
);
	localparam int unsigned KEY_LO = T_KEY_ON_MIN_MS * MS_CYCLES;
	localparam int unsigned KEY_HI = T_KEY_ON_MAX_MS * MS_CYCLES;
	localparam int unsigned UP_LO = (T_BOOT_MS - T_RAIL_UP_MS - 16'h0002) * MS_CYCLES;
	localparam int unsigned UP_HI = (T_ON_SEQ_MAX_MS - T_RAIL_UP_MS) * MS_CYCLES;
	localparam int unsigned OFF_HI = T_OFF_SEQ_MAX_MS * MS_CYCLES;
	localparam int unsigned RST_LO = T_EMERG_MS * MS_CYCLES;
	int unsigned key_cnt, rst_cnt, up_cnt, off_cnt;
	logic enum_seen, off_run;

	// Counters for long holds and waits, since repetition counts would be far too large.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			{key_cnt, rst_cnt, up_cnt, off_cnt} <= '0;
			{enum_seen, off_run} <= '0;
		end else begin
			key_cnt <= power_key_oe ? key_cnt + 32'h1 : '0;
			rst_cnt <= !emerg_reset_n ? rst_cnt + 32'h1 : '0;
			enum_seen <= io_rail_good && (enum_seen || usb_enum);
			up_cnt <= (io_rail_good && !enum_seen) ? up_cnt + 32'h1 : '0;
			off_run <= shutdown_command || (off_run && io_rail_good);
			off_cnt <= off_run ? off_cnt + 32'h1 : '0;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_io_needs_rail: assert property (host_io_oe |-> io_rail_good)
		else $error("host data pin driven while the rail is down");
	a_io_free_reset: assert property (!emerg_reset_n |-> !host_io_oe)
		else $error("host data pin driven during reset");
	a_io_free_cmd: assert property (shutdown_command |-> !host_io_oe)
		else $error("host data pin still driven at shutdown");
	a_unpower_safe: assert property ($fell(main_supply) |->
		!io_rail_good && !safe_to_unpower_n)
		else $error("supply removed before rail and safe flag fell");
	a_off_bound: assert property (off_cnt <= OFF_HI)
		else $error("power-off sequence too long");
	a_enum_once: assert property (usb_enum |-> !enum_seen)
		else $error("second enumeration within one boot");
	a_boot_time: assert property (usb_enum |-> up_cnt >= UP_LO && up_cnt <= UP_HI)
		else $error("enumeration outside boot time");
	a_press_len: assert property ($fell(power_key_oe) |->
		key_cnt >= KEY_LO && key_cnt <= KEY_HI)
		else $error("power key press length wrong");
	a_kill_key_free: assert property (!emerg_reset_n |-> power_key_n)
		else $error("power key held during emergency reset");
	a_kill_hold: assert property ($rose(emerg_reset_n) |-> rst_cnt >= RST_LO)
		else $error("emergency reset released too early");
	a_kill_off: assert property (rst_cnt == RST_LO + 2 * MS_CYCLES |->
		!safe_to_unpower_n && !io_rail_good)
		else $error("module not off after long reset");
endmodule

// ### bench/module_power_sequencing_tb.sv
/* Testbench joining the host sequencer to the module, plus two more modules run by the bench.
   Assumes a shortened millisecond tick so that every sequence fits a short run. */
`timescale 1ns/100ps
module module_power_sequencing_tb;
	import power_seq_pkg::*;
	localparam int unsigned MSC = 32'h2;
	logic ref_clk, rst, start_req, stop_req, kill_req, tx_bit;
	logic module_up, busy, timeout_fault, module_active, rx_bit, act_b, act_c;
	int err_count, n_compared, ta, tb;
	power_link lk();
	power_link lb();
	power_link lc();

	host_power_seq #(.MS_CYCLES(MSC)) u_host_power_seq (.ref_clk(ref_clk), .rst(rst),
		.link(lk.host), .start_req(start_req), .stop_req(stop_req), .kill_req(kill_req),
		.tx_bit(tx_bit), .module_up(module_up), .busy(busy), .timeout_fault(timeout_fault));
	modem_power_fsm #(.MS_CYCLES(MSC)) u_modem_power_fsm (.ref_clk(ref_clk), .rst(rst),
		.link(lk.modem), .quiet_boot_option(1'b0), .module_active(module_active),
		.rx_bit(rx_bit));
	// Second module whose host side the bench drives, to reach key and reset cases.
	modem_power_fsm #(.MS_CYCLES(MSC)) u_modem_power_fsm_b (.ref_clk(ref_clk), .rst(rst),
		.link(lb.modem), .quiet_boot_option(1'b0), .module_active(act_b), .rx_bit());
	// Third module with the quiet option on, so that the longer boot is seen.
	modem_power_fsm #(.MS_CYCLES(MSC)) u_modem_power_fsm_c (.ref_clk(ref_clk), .rst(rst),
		.link(lc.modem), .quiet_boot_option(1'b1), .module_active(act_c), .rx_bit());
	power_link_sva #(.MS_CYCLES(MSC)) u_power_link_sva (.ref_clk(ref_clk), .rst(rst),
		.main_supply(lk.main_supply), .power_key_oe(lk.power_key_oe),
		.power_key_n(lk.power_key_n), .emerg_reset_n(lk.emerg_reset_n),
		.shutdown_command(lk.shutdown_command), .io_rail_good(lk.io_rail_good),
		.safe_to_unpower_n(lk.safe_to_unpower_n), .usb_enum(lk.usb_enum),
		.host_io_oe(lk.host_io_oe));

	// Free-running clock at 100 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	function automatic int ms(input logic [15:0] v);
		return v * MSC;
	endfunction

	// True when a measured span lies within three ticks of its expected length.
	function automatic logic near(input int t, input int e);
		return t + ms(16'h0003) >= e && t <= e + ms(16'h0003);
	endfunction

	function automatic logic sig(input int sel);
		case (sel)
			0: return lk.usb_enum;
			1: return lb.io_rail_good;
			2: return lb.usb_enum;
			3: return lk.main_supply;
			default: return lb.safe_to_unpower_n;
		endcase
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Waits at falling edges for a level; the bound is the longest boot, so a hang shows.
	task automatic wait_lvl(input int sel, input logic lvl, output int t);
		t = 0;
		while (sig(sel) !== lvl && t < ms(T_ON_SEQ_MAX_MS)) begin
			@(negedge ref_clk);
			t++;
		end
	endtask

	// One-cycle request on the host user side: 0 start, 1 stop, 2 kill.
	task automatic pulse(input int sel);
		start_req = (sel == 0);
		stop_req = (sel == 1);
		kill_req = (sel == 2);
		@(negedge ref_clk);
		{start_req, stop_req, kill_req} = '0;
		@(negedge ref_clk);
	endtask

	task automatic end_of_test;
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Watchdog: the longest of the three threads needs about 65000 cycles.
	initial begin
		#800000;
		err_count++;
		end_of_test();
	end

	// Main sequence; all three links run side by side to keep the run short.
	initial begin
		{start_req, stop_req, kill_req, tx_bit} = '0;
		{lb.main_supply, lb.power_key_oe, lb.emerg_reset_oe, lb.shutdown_command} = '0;
		{lb.power_key_n_o, lb.emerg_reset_n_o, lb.host_io_o, lb.host_io_oe} = '0;
		{lc.main_supply, lc.power_key_oe, lc.emerg_reset_oe, lc.shutdown_command} = '0;
		{lc.power_key_n_o, lc.emerg_reset_n_o, lc.host_io_o, lc.host_io_oe} = '0;
		rst = 1'b1;
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		fork
			begin
				pulse(0);
				chk({lk.main_supply, lk.power_key_n, busy, lk.host_io_oe}, 4'hA);
				wait_lvl(0, 1'b1, ta);
				chk(near(ta, ms(T_KEY_ON_MIN_MS + T_BOOT_MS)), 1'b1);
				@(negedge ref_clk);
				chk({module_up, busy, lk.host_io_oe}, 3'h5);
				for (int b = 0; b < 2; b++) begin
					tx_bit = ~b[0];
					repeat (2) @(negedge ref_clk);
					chk(rx_bit, {31'h0, ~b[0]});
				end
				pulse(1);
				wait_lvl(3, 1'b0, ta);
				chk(near(ta, ms(T_OFF_DEV_MS + T_PWR_REMOVE_MS)), 1'b1);
				repeat (ms(T_KEY_OFF_MS)) @(negedge ref_clk);
				chk({lk.io_rail_good, lk.safe_to_unpower_n, module_active, module_up}, 4'h0);
				pulse(0);
				wait_lvl(0, 1'b1, ta);
				repeat (2) @(negedge ref_clk);
				pulse(2);
				@(negedge ref_clk);
				chk({lk.emerg_reset_n, lk.power_key_n, lk.io_rail_good, lk.host_io_oe}, 4'h4);
				wait_lvl(3, 1'b0, ta);
				chk(near(ta, ms(T_EMERG_HOLD_MS)), 1'b1);
				chk({timeout_fault, module_active}, 2'h0);
			end
			begin
				lb.power_key_oe = 1'b1;
				repeat (50) @(negedge ref_clk);
				lb.main_supply = 1'b1;
				wait_lvl(1, 1'b1, tb);
				chk(tb < ms(T_KEY_ON_MIN_MS + T_RAIL_UP_MS + 16'h0003), 1'b1);
				lb.power_key_oe = 1'b0;
				wait_lvl(2, 1'b1, tb);
				chk(near(tb, ms(T_BOOT_MS - T_RAIL_UP_MS)), 1'b1);
				@(negedge ref_clk);
				chk(act_b, 1'b1);
				lb.power_key_oe = 1'b1;
				lb.shutdown_command = 1'b1;
				@(negedge ref_clk);
				lb.shutdown_command = 1'b0;
				wait_lvl(1, 1'b0, tb);
				chk(near(tb, ms(T_OFF_DEV_MS + T_PWR_REMOVE_MS)), 1'b1);
				lb.power_key_oe = 1'b0;
				wait_lvl(1, 1'b1, tb);
				chk(near(tb, ms(T_RAIL_UP_MS)), 1'b1);
				wait_lvl(2, 1'b1, tb);
				chk(near(tb, ms(T_BOOT_MS - T_RAIL_UP_MS)), 1'b1);
				lb.power_key_oe = 1'b1;
				lb.emerg_reset_oe = 1'b1;
				repeat (2) @(negedge ref_clk);
				chk({lb.io_rail_good, act_b}, 2'h0);
				{lb.emerg_reset_oe, lb.power_key_oe} = '0;
				wait_lvl(1, 1'b1, tb);
				chk(near(tb, ms(T_RAIL_UP_MS)), 1'b1);
				wait_lvl(2, 1'b1, tb);
				lb.power_key_oe = 1'b1;
				wait_lvl(4, 1'b0, tb);
				chk(near(tb, ms(T_KEY_OFF_MS + T_OFF_DEV_MS)), 1'b1);
				lb.power_key_oe = 1'b0;
				// Key held through a whole boot: the module starts, then stops once let go.
				repeat (ms(T_OFF_DEV_MS)) @(negedge ref_clk);
				lb.power_key_oe = 1'b1;
				wait_lvl(2, 1'b1, tb);
				chk(near(tb, ms(T_KEY_ON_MIN_MS + T_BOOT_MS)), 1'b1);
				repeat (ms(T_KEY_OFF_MS)) @(negedge ref_clk);
				chk(act_b, 1'b1);
				lb.power_key_oe = 1'b0;
				wait_lvl(4, 1'b0, tb);
				chk(near(tb, ms(T_OFF_DEV_MS)), 1'b1);
			end
			begin
				// Supply before key, quiet option on: still booting when a plain boot is done.
				lc.main_supply = 1'b1;
				repeat (ms(T_RAIL_UP_MS)) @(negedge ref_clk);
				lc.power_key_oe = 1'b1;
				repeat (ms(T_PRESS_MS)) @(negedge ref_clk);
				lc.power_key_oe = 1'b0;
				chk(lc.safe_to_unpower_n, 1'b1);
				repeat (ms(T_BOOT_MS + T_RAIL_UP_MS)) @(negedge ref_clk);
				chk({lc.io_rail_good, lc.safe_to_unpower_n, act_c}, 3'h6);
			end
		join
		end_of_test();
	end
endmodule
